// ==== inc/dspcs_defines.svh ====
// constants and address map of the vector module control/status block
`ifndef DSPCS_DEFINES_SVH
`define DSPCS_DEFINES_SVH
`define DSPCS_RAM_BASE    32'hFFFE_0000
`define DSPCS_RAM_MASK    32'hFFFF_F000
`define DSPCS_DED_BASE    32'hFFFF_8000
`define DSPCS_DED_END     32'hFFFF_8028
`define DSPCS_CSR_BASE    32'hFFFF_9000
`define DSPCS_CSR_END     32'hFFFF_9018
`define DSPCS_OFS_LPTR    12'h020
`define DSPCS_OFS_OVF     12'h024
`define DSPCS_OFS_ABORT   12'h000
`define DSPCS_OFS_EXT     12'h004
`define DSPCS_OFS_STAT    12'h008
`define DSPCS_OFS_HINT    12'h00C
`define DSPCS_OFS_HMASK   12'h010
`define DSPCS_OFS_NMI     12'h014
`define DSPCS_NMI_EXT     0
`define DSPCS_NMI_UNDEF   1
`define DSPCS_NMI_ERR     2
`define DSPCS_OVF_OVF     0
`define DSPCS_OVF_SAT     1
`define DSPCS_RESP_OKAY   2'h0
`define DSPCS_RESP_DECERR 2'h3
`define DSPCS_ZERO16      16'h0000
`endif

// ==== inc/dspcs_pkg.sv ====
// types shared by the control/status block and its sequencer
package dspcs_pkg;
  // register selected by a bus address
  typedef enum logic [3:0] {
    DSPCS_R_NONE, DSPCS_R_RAM, DSPCS_R_DED, DSPCS_R_LPTR, DSPCS_R_OVF,
    DSPCS_R_ABORT, DSPCS_R_EXT, DSPCS_R_STAT, DSPCS_R_HINT, DSPCS_R_HMASK, DSPCS_R_NMI
  } dspcs_reg_t;
  // sequencer states
  typedef enum logic [1:0] {DSPCS_S_IDLE, DSPCS_S_RUN, DSPCS_S_STALL} dspcs_state_t;
  // events from the command-list datapath
  typedef struct packed {
    logic ext_req;
    logic list_end;
    logic undef;
    logic ovf_set;
    logic sat_set;
    logic ovf_rd;
  } dspcs_cl_in_t;
  // control towards the command-list datapath
  typedef struct packed {
    logic        run;
    logic        stall;
    logic        ext_grant;
    logic        start;
    logic        abort;
    logic [15:0] start_addr;
  } dspcs_cl_out_t;
endpackage

// ==== rtl/dspcs_seq.sv ====
// command-list run/stall sequencer
`timescale 1ns/1ns
module dspcs_seq (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  input  wire logic abort,
  input  wire logic hold,
  input  wire logic ext_req,
  input  wire logic list_end,
  output logic      run_ff,
  output logic      stall_ff,
  output logic      grant_ff,
  output logic      stop_ff
);
  dspcs_pkg::dspcs_state_t state_ff;
  dspcs_pkg::dspcs_state_t nxt_state;
  logic                    nxt_grant;
  logic                    nxt_stop;

  // next state; abort beats everything
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      dspcs_pkg::DSPCS_S_IDLE:
        if (start && !abort) nxt_state = dspcs_pkg::DSPCS_S_RUN;
      dspcs_pkg::DSPCS_S_RUN:
        if (abort || list_end) nxt_state = dspcs_pkg::DSPCS_S_IDLE;
        else if (ext_req && hold) nxt_state = dspcs_pkg::DSPCS_S_STALL;
      dspcs_pkg::DSPCS_S_STALL:
        if (abort) nxt_state = dspcs_pkg::DSPCS_S_IDLE;
        else if (!hold) nxt_state = dspcs_pkg::DSPCS_S_RUN;
      default:
        nxt_state = dspcs_pkg::DSPCS_S_IDLE;
    endcase
    // reference only goes out when hold was seen low
    nxt_grant = (nxt_state == dspcs_pkg::DSPCS_S_RUN) && ext_req && !hold;
    // abort stops are not reported: abort clears the halt flag anyway
    nxt_stop = (state_ff == dspcs_pkg::DSPCS_S_RUN) && list_end && !abort;
  end

  // state registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= dspcs_pkg::DSPCS_S_IDLE;
      run_ff   <= 1'h0;
      stall_ff <= 1'h0;
      grant_ff <= 1'h0;
      stop_ff  <= 1'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      run_ff   <= (nxt_state != dspcs_pkg::DSPCS_S_IDLE);
      stall_ff <= (nxt_state == dspcs_pkg::DSPCS_S_STALL);
      grant_ff <= nxt_grant;
      stop_ff  <= nxt_stop;
    end
  end

  a_stall_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (stall_ff && hold && !abort) |=> stall_ff && !grant_ff)
    else $error("stall released while hold set");
endmodule

// ==== rtl/dspcs_top.sv ====
// control/status register bank of the vector module on an AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "dspcs_defines.svh"
module dspcs_top (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [31:0]              awaddr,
  input  wire logic [2:0]               awprot,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [31:0]              araddr,
  input  wire logic [2:0]               arprot,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  input  wire logic                     nmi_pin_n,
  input  wire dspcs_pkg::dspcs_cl_in_t  cl_in,
  output dspcs_pkg::dspcs_cl_out_t      cl_out,
  output logic                          irq_out_n,
  output logic                          nmi_req
);
  // bus state
  logic        aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [31:0] aw_addr_ff, nxt_aw_addr, w_data_ff, nxt_w_data;
  logic [3:0]  w_strb_ff, nxt_w_strb;
  logic        awready_ff, nxt_awready, wready_ff, nxt_wready, arready_ff, nxt_arready;
  logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  // register state
  logic        hold_ff, nxt_hold, mask_ff, nxt_mask, halt_ff, nxt_halt;
  logic [2:0]  nmi_ff, nxt_nmi;
  logic [1:0]  ovf_ff, nxt_ovf;
  logic [15:0] lptr_ff, nxt_lptr;
  logic        start_ff, nxt_start, abort_ff, irq_n_ff, nxt_irq_n, nmi_req_ff;
  logic        nmi_s1_ff, nmi_s2_ff, nmi_s3_ff;
  // decode and events
  logic        aw_hs, w_hs, ar_hs, wr_fire;
  logic [31:0] wr_addr, wr_data;
  logic [3:0]  wr_strb;
  logic [15:0] rd_val;
  logic        abort_wr, lptr_wr, busy_err, rd_hint, rd_nmi, rd_ovf, nmi_fall;
  logic        run, stall, grant, stop;
  dspcs_pkg::dspcs_reg_t w_sel, r_sel;

  // address window decode
  function automatic dspcs_pkg::dspcs_reg_t dec(input logic [31:0] a);
    logic [11:0] ofs;
    ofs = {a[11:2], 2'h0};
    dec = dspcs_pkg::DSPCS_R_NONE;
    if ((a & `DSPCS_RAM_MASK) == `DSPCS_RAM_BASE)
      dec = dspcs_pkg::DSPCS_R_RAM;
    else if (a >= `DSPCS_DED_BASE && a < `DSPCS_DED_END)
    begin
      if (ofs == `DSPCS_OFS_LPTR) dec = dspcs_pkg::DSPCS_R_LPTR;
      else if (ofs == `DSPCS_OFS_OVF) dec = dspcs_pkg::DSPCS_R_OVF;
      else dec = dspcs_pkg::DSPCS_R_DED;
    end
    else if (a >= `DSPCS_CSR_BASE && a < `DSPCS_CSR_END)
    begin
      case (ofs)
        `DSPCS_OFS_ABORT:  dec = dspcs_pkg::DSPCS_R_ABORT;
        `DSPCS_OFS_EXT:    dec = dspcs_pkg::DSPCS_R_EXT;
        `DSPCS_OFS_STAT:   dec = dspcs_pkg::DSPCS_R_STAT;
        `DSPCS_OFS_HINT:   dec = dspcs_pkg::DSPCS_R_HINT;
        `DSPCS_OFS_HMASK:  dec = dspcs_pkg::DSPCS_R_HMASK;
        default:           dec = dspcs_pkg::DSPCS_R_NMI;
      endcase
    end
  endfunction

  // access to a register that is off limits while the list runs
  function automatic logic busy_reg(input dspcs_pkg::dspcs_reg_t s);
    busy_reg = (s == dspcs_pkg::DSPCS_R_RAM) || (s == dspcs_pkg::DSPCS_R_DED) ||
               (s == dspcs_pkg::DSPCS_R_LPTR) || (s == dspcs_pkg::DSPCS_R_OVF);
  endfunction

  // handshakes and request decode
  assign aw_hs    = awvalid && awready_ff;
  assign w_hs     = wvalid && wready_ff;
  assign ar_hs    = arvalid && arready_ff;
  assign wr_fire  = (aw_have_ff || aw_hs) && (w_have_ff || w_hs) && !bvalid_ff;
  assign wr_addr  = aw_have_ff ? aw_addr_ff : awaddr;
  assign wr_data  = w_have_ff ? w_data_ff : wdata;
  assign wr_strb  = w_have_ff ? w_strb_ff : wstrb;
  assign w_sel    = dec(wr_addr);
  assign r_sel    = dec(araddr);
  // only the bus can reach the abort register
  assign abort_wr = wr_fire && (w_sel == dspcs_pkg::DSPCS_R_ABORT);
  // pointer is only loadable while idle
  assign lptr_wr  = wr_fire && (w_sel == dspcs_pkg::DSPCS_R_LPTR) && !run;
  assign busy_err = run && ((wr_fire && busy_reg(w_sel)) || (ar_hs && busy_reg(r_sel)));
  assign rd_hint  = ar_hs && (r_sel == dspcs_pkg::DSPCS_R_HINT);
  assign rd_nmi   = ar_hs && (r_sel == dspcs_pkg::DSPCS_R_NMI);
  assign rd_ovf   = ar_hs && (r_sel == dspcs_pkg::DSPCS_R_OVF) && !run;
  assign nmi_fall = nmi_s3_ff && !nmi_s2_ff;

  // read data mux; reserved and write-only bits read zero
  always_comb
  begin
    rd_val = `DSPCS_ZERO16;
    case (r_sel)
      dspcs_pkg::DSPCS_R_LPTR:   rd_val = run ? `DSPCS_ZERO16 : lptr_ff;
      dspcs_pkg::DSPCS_R_OVF:    rd_val = run ? `DSPCS_ZERO16 : {14'h0000, ovf_ff};
      dspcs_pkg::DSPCS_R_EXT:    rd_val = {15'h0000, hold_ff};
      dspcs_pkg::DSPCS_R_STAT:   rd_val = {15'h0000, run};
      dspcs_pkg::DSPCS_R_HINT:   rd_val = {15'h0000, halt_ff};
      dspcs_pkg::DSPCS_R_HMASK:  rd_val = {15'h0000, mask_ff};
      dspcs_pkg::DSPCS_R_NMI:    rd_val = {13'h0000, nmi_ff};
      default:                   rd_val = `DSPCS_ZERO16;
    endcase
  end

  // AXI4-Lite channel control; one write and one read in flight
  always_comb
  begin
    nxt_aw_have = aw_have_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_have  = w_have_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (aw_hs)
    begin
      nxt_aw_have = 1'h1;
      nxt_aw_addr = awaddr;
    end
    if (w_hs)
    begin
      nxt_w_have = 1'h1;
      nxt_w_data = wdata;
      nxt_w_strb = wstrb;
    end
    if (bvalid_ff && bready) nxt_bvalid = 1'h0;
    if (wr_fire)
    begin
      nxt_aw_have = 1'h0;
      nxt_w_have  = 1'h0;
      nxt_bvalid  = 1'h1;
      nxt_bresp   = (w_sel == dspcs_pkg::DSPCS_R_NONE) ? `DSPCS_RESP_DECERR : `DSPCS_RESP_OKAY;
    end
    if (rvalid_ff && rready) nxt_rvalid = 1'h0;
    if (ar_hs)
    begin
      nxt_rvalid = 1'h1;
      nxt_rdata  = {`DSPCS_ZERO16, rd_val};
      nxt_rresp  = (r_sel == dspcs_pkg::DSPCS_R_NONE) ? `DSPCS_RESP_DECERR : `DSPCS_RESP_OKAY;
    end
    // ready drops while an answer waits, so nothing is taken twice
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready  = !nxt_w_have && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  // bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_ff <= 1'h0;
      aw_addr_ff <= 32'h0000_0000;
      w_have_ff  <= 1'h0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      awready_ff <= 1'h0;
      wready_ff  <= 1'h0;
      arready_ff <= 1'h0;
      bvalid_ff  <= 1'h0;
      bresp_ff   <= `DSPCS_RESP_OKAY;
      rvalid_ff  <= 1'h0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `DSPCS_RESP_OKAY;
    end
    else
    begin
      aw_have_ff <= nxt_aw_have;
      aw_addr_ff <= nxt_aw_addr;
      w_have_ff  <= nxt_w_have;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      arready_ff <= nxt_arready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // control and status next values; a setting event wins over a read clear
  always_comb
  begin
    nxt_hold  = hold_ff;
    nxt_mask  = mask_ff;
    nxt_lptr  = lptr_ff;
    if (wr_fire && wr_strb[0] && (w_sel == dspcs_pkg::DSPCS_R_EXT)) nxt_hold = wr_data[0];
    if (wr_fire && wr_strb[0] && (w_sel == dspcs_pkg::DSPCS_R_HMASK)) nxt_mask = wr_data[0];
    if (lptr_wr && wr_strb[0]) nxt_lptr[7:0] = wr_data[7:0];
    if (lptr_wr && wr_strb[1]) nxt_lptr[15:8] = wr_data[15:8];
    nxt_halt = stop || (halt_ff && !rd_hint);
    nxt_ovf[`DSPCS_OVF_OVF] = cl_in.ovf_set || (ovf_ff[`DSPCS_OVF_OVF] && !(rd_ovf || cl_in.ovf_rd));
    nxt_ovf[`DSPCS_OVF_SAT] = cl_in.sat_set || (ovf_ff[`DSPCS_OVF_SAT] && !(rd_ovf || cl_in.ovf_rd));
    // abort is an explicit clear and overrides the datapath events
    if (abort_wr)
    begin
      nxt_hold = 1'h0;
      nxt_mask = 1'h0;
      nxt_halt = 1'h0;
      nxt_ovf  = 2'h0;
    end
    nxt_nmi[`DSPCS_NMI_ERR] = busy_err || (nmi_ff[`DSPCS_NMI_ERR] && !rd_nmi);
    nxt_nmi[`DSPCS_NMI_UNDEF] = cl_in.undef || (nmi_ff[`DSPCS_NMI_UNDEF] && !rd_nmi);
    nxt_nmi[`DSPCS_NMI_EXT] = nmi_fall || (nmi_ff[`DSPCS_NMI_EXT] && !rd_nmi);
    nxt_start = lptr_wr && !abort_wr;
    nxt_irq_n = !(nxt_halt && nxt_mask);
  end

  // control and status registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_ff    <= 1'h0;
      mask_ff    <= 1'h0;
      halt_ff    <= 1'h0;
      ovf_ff     <= 2'h0;
      nmi_ff     <= 3'h0;
      lptr_ff    <= `DSPCS_ZERO16;
      start_ff   <= 1'h0;
      abort_ff   <= 1'h0;
      irq_n_ff   <= 1'h1;
      nmi_req_ff <= 1'h0;
    end
    else
    begin
      hold_ff    <= nxt_hold;
      mask_ff    <= nxt_mask;
      halt_ff    <= nxt_halt;
      ovf_ff     <= nxt_ovf;
      nmi_ff     <= nxt_nmi;
      lptr_ff    <= nxt_lptr;
      start_ff   <= nxt_start;
      abort_ff   <= abort_wr;
      irq_n_ff   <= nxt_irq_n;
      nmi_req_ff <= |nxt_nmi;
    end
  end

  // pin synchroniser; the edge is judged on the second and third stage only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_s1_ff <= 1'h1;
      nmi_s2_ff <= 1'h1;
      nmi_s3_ff <= 1'h1;
    end
    else
    begin
      nmi_s1_ff <= nmi_pin_n;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_s3_ff <= nmi_s2_ff;
    end
  end

  // run state lives in the sequencer; start and abort reach it combinationally
  dspcs_seq u_seq (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (lptr_wr),
    .abort    (abort_wr),
    .hold     (hold_ff),
    .ext_req  (cl_in.ext_req),
    .list_end (cl_in.list_end),
    .run_ff   (run),
    .stall_ff (stall),
    .grant_ff (grant),
    .stop_ff  (stop)
  );

  assign awready   = awready_ff;
  assign wready    = wready_ff;
  assign bvalid    = bvalid_ff;
  assign bresp     = bresp_ff;
  assign arready   = arready_ff;
  assign rvalid    = rvalid_ff;
  assign rdata     = rdata_ff;
  assign rresp     = rresp_ff;
  assign irq_out_n = irq_n_ff;
  assign nmi_req   = nmi_req_ff;
  assign cl_out    = '{run: run, stall: stall, ext_grant: grant, start: start_ff,
                       abort: abort_ff, start_addr: lptr_ff};

  // multi-step behaviours
  sequence s_pin_fall;
    nmi_s3_ff && !nmi_s2_ff;
  endsequence
  sequence s_idle_load;
    lptr_wr && !abort_wr;
  endsequence

  a_abort_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    abort_wr |=> !hold_ff && !mask_ff && !halt_ff && (ovf_ff == 2'h0) && !run)
    else $error("abort left state set");
  a_abort_readz: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && r_sel == dspcs_pkg::DSPCS_R_ABORT) |=> rdata_ff == 32'h0000_0000)
    else $error("abort register readable");
  a_grant_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    grant |-> !$past(hold_ff) && $past(cl_in.ext_req))
    else $error("reference granted under hold");
  a_hold_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && !stall && cl_in.ext_req && hold_ff && !cl_in.list_end && !abort_wr) |=> stall && !grant)
    else $error("hold did not stall");
  a_status_run: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && r_sel == dspcs_pkg::DSPCS_R_STAT) |=> rdata_ff[0] == $past(run))
    else $error("status bit differs from run");
  a_halt_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (stop && !abort_wr) |-> $fell(run) ##1 halt_ff)
    else $error("stop did not set halt");
  a_halt_rdclr: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_hint && !stop) |=> !halt_ff)
    else $error("halt flag not cleared by read");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (irq_out_n == !(halt_ff && mask_ff)))
    else $error("interrupt output wrong");
  a_busy_err: assert property (@(posedge aclk) disable iff (!aresetn)
    busy_err |=> nmi_ff[`DSPCS_NMI_ERR] ##0 nmi_req)
    else $error("busy access not flagged");
  a_pin_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(nmi_pin_n) |-> ##2 s_pin_fall ##1 nmi_ff[`DSPCS_NMI_EXT])
    else $error("pin edge not captured");
  a_nmi_req: assert property (@(posedge aclk) disable iff (!aresetn)
    nmi_req == (nmi_ff != 3'h0))
    else $error("nonmaskable request mismatch");
  a_nmi_rdclr: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_nmi && !busy_err && !cl_in.undef && !nmi_fall) |=> nmi_ff == 3'h0)
    else $error("nonmaskable status not cleared");
  a_load_runs: assert property (@(posedge aclk) disable iff (!aresetn)
    s_idle_load |=> run && cl_out.start ##1 !cl_out.start)
    else $error("pointer write did not start");
endmodule

// ==== tb/dspcs_cl_model.sv ====
// behavioural command-list datapath facing the sequencer outputs
`timescale 1ns/1ns
module dspcs_cl_model (
  input  wire logic                    aclk,
  input  wire logic                    want_ext,
  input  wire logic                    end_go,
  input  wire logic                    undef_go,
  input  wire logic                    ovf_go,
  input  wire dspcs_pkg::dspcs_cl_out_t cl_out,
  output dspcs_pkg::dspcs_cl_in_t      cl_in,
  output logic                         got_ext
);
  dspcs_pkg::dspcs_cl_in_t q_ff = '0;
  logic                    g_ff = 1'b0;
  assign cl_in   = q_ff;
  assign got_ext = g_ff;
  // reference proceeds only in a granted cycle, else it keeps asking
  always @(posedge aclk)
  begin
    q_ff.ext_req  <= want_ext;
    g_ff          <= q_ff.ext_req & cl_out.ext_grant;
    q_ff.list_end <= end_go & cl_out.run;  // ends only a running list
    q_ff.undef    <= undef_go;
    q_ff.ovf_set  <= ovf_go;
    q_ff.sat_set  <= ovf_go;
  end
endmodule

// ==== tb/dsp_module_control_status_tb.sv ====
// self-checking bench of the vector module control/status block
`timescale 1ns/1ns
`include "dspcs_defines.svh"
module dsp_module_control_status_tb;
  logic                     aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic                     awready, wready, bvalid, arready, rvalid, irq_out_n, nmi_req, nmi_pin_n;
  logic                     want_ext, got_ext;
  logic [2:0]               go;  // list end, bad instruction, overflow pulses
  logic [31:0]              awaddr, wdata, araddr, rdata, rd, rnd;
  logic [1:0]               bresp, rresp, rs;
  dspcs_pkg::dspcs_cl_in_t  cl_in;
  dspcs_pkg::dspcs_cl_out_t cl_out;
  int                       n_fail, num_checks, cyc, m_mask;
  dspcs_top u_dspcs_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .nmi_pin_n(nmi_pin_n), .cl_in(cl_in),
    .cl_out(cl_out), .irq_out_n(irq_out_n), .nmi_req(nmi_req));
  dspcs_cl_model u_dspcs_cl_model (.aclk(aclk), .want_ext(want_ext), .end_go(go[0]), .undef_go(go[1]),
    .ovf_go(go[2]), .cl_out(cl_out), .cl_in(cl_in), .got_ext(got_ext));
  // clock, 8 ns period
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] csr(input logic [11:0] o);
    return `DSPCS_CSR_BASE + {20'h0_0000, o};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // master write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        rs = bresp;
        break;
      end
    end
    // bubble: the next call must not raise bready in this same time step
    @(posedge aclk);
  endtask
  task automatic rdw(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
        break;
      end
    end
    // bubble: the next call must not raise rready in this same time step
    @(posedge aclk);
  endtask
  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    rdw(a);
    chk(nm, rd, exp);
  endtask
  task automatic pulse(input int k);
    go[k] <= 1'b1;
    @(posedge aclk);
    go[k] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  // hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_fail++;
      test_done();
    end
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, want_ext} = '0;
    go = 3'h0;
    {awaddr, wdata, araddr} = '0;
    {n_fail, num_checks, cyc} = '0;
    nmi_pin_n = 1'b1;
    aresetn = 1'b0;
    rnd = 32'h0001_736C;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("ext_rst", csr(`DSPCS_OFS_EXT), 32'h0000_0000);
    rchk("stat_rst", csr(`DSPCS_OFS_STAT), 32'h0000_0000);
    rchk("hint_rst", csr(`DSPCS_OFS_HINT), 32'h0000_0000);
    rchk("mask_rst", csr(`DSPCS_OFS_HMASK), 32'h0000_0000);
    rchk("nmi_rst", csr(`DSPCS_OFS_NMI), 32'h0000_0000);
    rchk("abort_rd", csr(`DSPCS_OFS_ABORT), 32'h0000_0000);
    rchk("ram_rd", `DSPCS_RAM_BASE, 32'h0000_0000);
    chk("ram_resp", rs, `DSPCS_RESP_OKAY);
    rdw(32'h0000_1000);
    chk("unmap_resp", rs, `DSPCS_RESP_DECERR);
    wr(32'h0000_1000, 32'h0000_0001);
    chk("unmap_wresp", rs, `DSPCS_RESP_DECERR);
    wr(csr(`DSPCS_OFS_STAT), 32'hFFFF_FFFF);
    rchk("stat_ro", csr(`DSPCS_OFS_STAT), 32'h0000_0000);
    // random mask values, only the halt bit is kept
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      m_mask = rnd[0];
      wr(csr(`DSPCS_OFS_HMASK), rnd);
      rchk("mask_rw", csr(`DSPCS_OFS_HMASK), 32'(m_mask));
    end
    wr(csr(`DSPCS_OFS_HMASK), 32'h0000_0001);
    wr(csr(`DSPCS_OFS_EXT), 32'h0000_0001);
    rchk("ext_rw", csr(`DSPCS_OFS_EXT), 32'h0000_0001);
    wr(`DSPCS_DED_BASE + 32'h0000_0020, 32'h0000_0040);
    chk("run_start", 32'(cl_out.run), 32'h0000_0001);
    chk("start_addr", 32'(cl_out.start_addr), 32'h0000_0040);
    rchk("stat_run", csr(`DSPCS_OFS_STAT), 32'h0000_0001);
    want_ext <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("stall", 32'(cl_out.stall), 32'h0000_0001);
    chk("no_grant", 32'(got_ext), 32'h0000_0000);
    wr(csr(`DSPCS_OFS_EXT), 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk("grant", 32'(got_ext), 32'h0000_0001);
    chk("unstall", 32'(cl_out.stall), 32'h0000_0000);
    want_ext <= 1'b0;
    rdw(`DSPCS_DED_BASE);
    @(posedge aclk);
    chk("err_req", 32'(nmi_req), 32'h0000_0001);
    pulse(0);
    chk("run_end", 32'(cl_out.run), 32'h0000_0000);
    chk("irq_on", 32'(irq_out_n), 32'h0000_0000);
    rchk("stat_idle", csr(`DSPCS_OFS_STAT), 32'h0000_0000);
    rchk("halt_set", csr(`DSPCS_OFS_HINT), 32'h0000_0001);
    rchk("halt_rc", csr(`DSPCS_OFS_HINT), 32'h0000_0000);
    rchk("nmi_err", csr(`DSPCS_OFS_NMI), 32'h0000_0004);
    rchk("nmi_rc", csr(`DSPCS_OFS_NMI), 32'h0000_0000);
    pulse(1);
    rchk("nmi_und", csr(`DSPCS_OFS_NMI), 32'h0000_0002);
    nmi_pin_n <= 1'b0;
    pulse(1);
    nmi_pin_n <= 1'b1;
    chk("nmi_pin", 32'(nmi_req), 32'h0000_0001);
    rchk("nmi_ext", csr(`DSPCS_OFS_NMI), 32'h0000_0003);
    // overflow and saturation set while idle, then cleared by the read
    pulse(2);
    rchk("ovf_set", `DSPCS_DED_BASE + 32'h0000_0024, 32'h0000_0003);
    rchk("ovf_rc", `DSPCS_DED_BASE + 32'h0000_0024, 32'h0000_0000);
    // abort in mid-run clears hold, mask and halt flag
    wr(csr(`DSPCS_OFS_EXT), 32'h0000_0001);
    wr(`DSPCS_DED_BASE + 32'h0000_0020, 32'h0000_0010);
    // overflow raised in the run, so the abort has something to clear
    pulse(2);
    wr(csr(`DSPCS_OFS_ABORT), 32'h0000_0000);
    chk("abort_run", 32'(cl_out.run), 32'h0000_0000);
    rchk("abort_ext", csr(`DSPCS_OFS_EXT), 32'h0000_0000);
    rchk("abort_mask", csr(`DSPCS_OFS_HMASK), 32'h0000_0000);
    rchk("abort_hint", csr(`DSPCS_OFS_HINT), 32'h0000_0000);
    rchk("ovf_clr", `DSPCS_DED_BASE + 32'h0000_0024, 32'h0000_0000);
    chk("irq_off", 32'(irq_out_n), 32'h0000_0001);
    test_done();
  end
endmodule
